// >>> sci_defs.svh
// Constants for the synchronous DRAM command interface: command codes,
// mode word fields, timing counts and the controller's register map.
// Included by both ends, the link assertions and the bench.
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// ----------------------------------------------------------------------
// Commands as {ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define SCI_CMD_MRS        3'h0
`define SCI_CMD_REF        3'h1
`define SCI_CMD_PRE        3'h2
`define SCI_CMD_ACT        3'h3
`define SCI_CMD_WR         3'h4
`define SCI_CMD_RD         3'h5
`define SCI_CMD_BST        3'h6
`define SCI_CMD_NOP        3'h7

// ----------------------------------------------------------------------
// Address fields and mode word
// ----------------------------------------------------------------------
`define SCI_AP_BIT         10
`define SCI_COL_MSB        9
`define SCI_MR_BL          2:0
`define SCI_MR_BT          3
`define SCI_MR_CL          6:4
`define SCI_MR_WB          9
`define SCI_MR_RESET       13'h0020
`define SCI_BL_1           3'h0
`define SCI_BL_2           3'h1
`define SCI_BL_4           3'h2
`define SCI_BL_8           3'h3
`define SCI_WORDS_1        11'h001
`define SCI_WORDS_2        11'h002
`define SCI_WORDS_4        11'h004
`define SCI_WORDS_8        11'h008
`define SCI_WORDS_PAGE     11'h400
`define SCI_CL_THREE       3'h3
`define SCI_STORE_WORDS    256

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCI_CLK_NS         25
`define SCI_T_RC_NS        90
`define SCI_RC_CYC         ((`SCI_T_RC_NS + `SCI_CLK_NS - 1) / `SCI_CLK_NS)
`define SCI_REF_MS         64
`define SCI_ROWS           8192
`define SCI_REF_CYC        ((`SCI_REF_MS * 1000000) / (`SCI_ROWS * `SCI_CLK_NS))

// ----------------------------------------------------------------------
// Controller registers (byte offsets) and fields
// ----------------------------------------------------------------------
`define SCI_REG_CTRL       8'h00
`define SCI_REG_CMD        8'h04
`define SCI_REG_ADDR       8'h08
`define SCI_REG_WDATA      8'h0c
`define SCI_REG_RDATA      8'h10
`define SCI_REG_STATUS     8'h14
`define SCI_REG_MASK       8'h18
`define SCI_CTRL_LP        0
`define SCI_CTRL_SELF      1
`define SCI_CTRL_REF_EN    2
`define SCI_CMD_F_CODE     2:0
`define SCI_CMD_F_BANK     5:4

`endif

// >>> sci_pkg.sv
// Types shared by both ends of the synchronous DRAM command interface.
// Constants live in sci_defs.svh.
package sci_pkg;
	typedef logic [2:0] sci_cmd_t;
	typedef enum logic [1:0] {sci_ms_run, sci_ms_power_down, sci_ms_self_refresh} sci_mem_state_t;
	typedef enum logic [2:0] {sci_cs_idle, sci_cs_gap, sci_cs_ref, sci_cs_lp_enter,
		sci_cs_lp} sci_ctrl_state_t;
endpackage

// >>> sci_if.sv
// Pin-level link between the memory controller and the memory.
// The shared data wires are resolved here from the two output enables.
`timescale 1ns/1ps
interface sci_if;
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [1:0]  bank_select;
	logic [12:0] addr;
	logic        lane_a_mask;
	logic        lane_b_mask;
	logic        lane_c_mask;
	logic        lane_d_mask;
	logic [31:0] dq_mem_out;
	logic [3:0]  dq_mem_oe_n;
	logic [31:0] dq_ctrl_out;
	logic        dq_ctrl_oe_n;
	logic [31:0] dq;

	// Memory wins only where it drives; a floating lane reads zero
	genvar i;
	for (i = 0; i < 4; i++) begin : g_lane
		assign dq[8*i +: 8] = !dq_mem_oe_n[i] ? dq_mem_out[8*i +: 8] :
			(!dq_ctrl_oe_n ? dq_ctrl_out[8*i +: 8] : 8'h00);
	end

	modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		lane_a_mask, lane_b_mask, lane_c_mask, lane_d_mask, dq,
		output dq_mem_out, dq_mem_oe_n);
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		lane_a_mask, lane_b_mask, lane_c_mask, lane_d_mask, dq_ctrl_out, dq_ctrl_oe_n,
		input dq);
endinterface

// >>> sci_mem.sv
// Memory end of the synchronous DRAM command interface: command decode,
// bank state, mode word, bursts, byte masks, refresh and low-power modes.
// Assumes pclk is the memory clock and presetn only brings up simulation.
//
// Functional notes
// - All inputs sampled on rising pclk only
// - Clock gate low freezes internal clock, low power
// - Deselect ignores all but clock, gate, masks
// - Command decoded from RAS CAS WE levels
// - Four banks chosen by bank select
// - Activate latches thirteen-bit row address
// - Read or write takes ten-bit start column
// - Auto-precharge bit closes bank after burst
// - Precharge with bit set closes all banks
// - Shared data wires, never both parties driving
// - Burst 1/2/4/8/page, sequential or interleaved
// - Single-word writes with burst reads mode
// - Four byte lanes, each with own mask
// - Auto refresh command and internal self refresh
// - Controller refreshes every row within 64 ms
// - Read mask floats lane two clocks later
// - Power-down only idle, exit before refresh due
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sci_defs.svh"
module sci_mem (
	input  wire logic        pclk,
	input  wire logic        presetn,
	sci_if.mem               link,
	output      logic [3:0]  bank_open,
	output      logic [1:0]  mem_state,
	output      logic [12:0] refresh_row
);
	sci_pkg::sci_mem_state_t state;
	sci_pkg::sci_cmd_t       cmd;
	logic        cke_q;
	logic        clk_run;
	logic        cmd_ok;
	logic [3:0]  mask_in;
	logic [12:0] mode_reg;
	logic [12:0] bank_row [4];
	logic        burst_on;
	logic        burst_wr;
	logic        burst_ap;
	logic [1:0]  burst_bank;
	logic [9:0]  burst_col;
	logic [10:0] burst_idx;
	logic [10:0] burst_len;
	logic [10:0] new_len;
	logic        burst_stop;
	logic        beat_do;
	logic        beat_wr;
	logic [1:0]  beat_bank;
	logic [9:0]  beat_col;
	logic        beat_last;
	logic [7:0]  beat_index;
	logic [31:0] beat_rdata;
	logic        ap_fire;
	logic [1:0]  ap_bank;
	logic [1:0]  pipe_v;
	logic [31:0] pipe_d [2];
	logic [3:0]  mask_d1;
	logic [8:0]  self_timer;
	logic        all_idle;

	// --------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------
	assign mask_in  = {link.lane_d_mask, link.lane_c_mask, link.lane_b_mask, link.lane_a_mask};
	assign cmd      = {link.ras_n, link.cas_n, link.we_n};
	assign clk_run  = cke_q && (state == sci_pkg::sci_ms_run);
	assign cmd_ok   = clk_run && !link.cs_n;
	assign all_idle = (bank_open == 4'h0) && !burst_on;
	assign mem_state = state;
	assign burst_stop = cmd_ok && (cmd == `SCI_CMD_BST || cmd == `SCI_CMD_PRE);

	function automatic logic [10:0] bl_words(input logic [2:0] code);
		case (code)
			`SCI_BL_1: bl_words = `SCI_WORDS_1;
			`SCI_BL_2: bl_words = `SCI_WORDS_2;
			`SCI_BL_4: bl_words = `SCI_WORDS_4;
			`SCI_BL_8: bl_words = `SCI_WORDS_8;
			default:   bl_words = `SCI_WORDS_PAGE;
		endcase
	endfunction

	// Wraps inside the burst-aligned block of the start column
	function automatic logic [9:0] walk_col(input logic [9:0] start, input logic [10:0] idx,
		input logic [10:0] len, input logic inter);
		logic [9:0] msk;
		logic [9:0] low;
		msk = 10'(len - 11'h001);
		low = inter ? ((start ^ idx[9:0]) & msk) : ((start + idx[9:0]) & msk);
		walk_col = (start & ~msk) | low;
	endfunction

	// --------------------------------------------------------------
	// Beat selection
	// --------------------------------------------------------------
	always_comb begin
		new_len = bl_words(mode_reg[`SCI_MR_BL]);
		if (cmd == `SCI_CMD_WR && mode_reg[`SCI_MR_WB])
			new_len = `SCI_WORDS_1;
		beat_do   = 1'b0;
		beat_wr   = 1'b0;
		beat_bank = burst_bank;
		beat_col  = burst_col;
		beat_last = 1'b0;
		if (cmd_ok && (cmd == `SCI_CMD_RD || cmd == `SCI_CMD_WR)) begin
			beat_do   = 1'b1;
			beat_wr   = (cmd == `SCI_CMD_WR);
			beat_bank = link.bank_select;
			beat_col  = link.addr[`SCI_COL_MSB:0];
			beat_last = (new_len == `SCI_WORDS_1);
		end else if (burst_on && clk_run && !burst_stop) begin
			beat_do   = 1'b1;
			beat_wr   = burst_wr;
			beat_col  = walk_col(burst_col, burst_idx, burst_len, mode_reg[`SCI_MR_BT]);
			beat_last = (burst_idx == burst_len - 11'h001) && (burst_len != `SCI_WORDS_PAGE);
		end
		beat_index = {beat_bank, bank_row[beat_bank][1:0], beat_col[3:0]};
	end

	always_comb begin
		ap_fire = 1'b0;
		ap_bank = burst_bank;
		if (beat_do && beat_last) begin
			if (cmd_ok && (cmd == `SCI_CMD_RD || cmd == `SCI_CMD_WR)) begin
				ap_fire = link.addr[`SCI_AP_BIT];
				ap_bank = link.bank_select;
			end else begin
				ap_fire = burst_ap;
			end
		end
	end

	// --------------------------------------------------------------
	// Clock gate and power state
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cke_q <= 1'b0;
		else
			cke_q <= link.cke;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= sci_pkg::sci_ms_run;
		end else begin
			unique case (state)
				sci_pkg::sci_ms_run: begin
					if (cke_q && !link.cke && all_idle) begin
						if (cmd_ok && cmd == `SCI_CMD_REF)
							state <= sci_pkg::sci_ms_self_refresh;
						else if (link.cs_n || cmd == `SCI_CMD_NOP)
							state <= sci_pkg::sci_ms_power_down;
					end
				end
				sci_pkg::sci_ms_power_down,
				sci_pkg::sci_ms_self_refresh: begin
					if (link.cke)
						state <= sci_pkg::sci_ms_run;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Mode word
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_reg <= `SCI_MR_RESET;
		else if (cmd_ok && cmd == `SCI_CMD_MRS && all_idle)
			mode_reg <= link.addr;
	end

	// --------------------------------------------------------------
	// Bank state
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_open <= 4'h0;
			for (int b = 0; b < 4; b++)
				bank_row[b] <= 13'h0000;
		end else begin
			if (cmd_ok && cmd == `SCI_CMD_ACT) begin
				bank_open[link.bank_select] <= 1'b1;
				bank_row[link.bank_select]  <= link.addr;
			end
			if (ap_fire)
				bank_open[ap_bank] <= 1'b0;
			if (cmd_ok && cmd == `SCI_CMD_PRE) begin
				if (link.addr[`SCI_AP_BIT])
					bank_open <= 4'h0;
				else
					bank_open[link.bank_select] <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Burst tracking
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_on   <= 1'b0;
			burst_wr   <= 1'b0;
			burst_ap   <= 1'b0;
			burst_bank <= 2'h0;
			burst_col  <= 10'h000;
			burst_idx  <= 11'h000;
			burst_len  <= `SCI_WORDS_1;
		end else if (cmd_ok && (cmd == `SCI_CMD_RD || cmd == `SCI_CMD_WR)) begin
			burst_on   <= !beat_last;
			burst_wr   <= (cmd == `SCI_CMD_WR);
			burst_ap   <= link.addr[`SCI_AP_BIT];
			burst_bank <= link.bank_select;
			burst_col  <= link.addr[`SCI_COL_MSB:0];
			burst_idx  <= 11'h001;
			burst_len  <= new_len;
		end else if (burst_stop) begin
			burst_on <= 1'b0;
		end else if (beat_do) begin
			burst_on  <= !beat_last;
			burst_idx <= burst_idx + 11'h001;
		end
	end

	// --------------------------------------------------------------
	// Byte lanes: storage, write mask, read drive
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_d1 <= 4'h0;
		else
			mask_d1 <= mask_in;  // Masks are honoured even when deselected
	end

	genvar ln;
	for (ln = 0; ln < 4; ln++) begin : g_lane
		logic [7:0] lane_store [`SCI_STORE_WORDS];
		assign beat_rdata[8*ln +: 8] = lane_store[beat_index];
		always_ff @(posedge pclk) begin
			if (beat_do && beat_wr && !mask_in[ln])
				lane_store[beat_index] <= link.dq[8*ln +: 8];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				link.dq_mem_oe_n[ln] <= 1'b1;
			else if (clk_run)
				link.dq_mem_oe_n[ln] <= !(pipe_v[mode_reg[`SCI_MR_CL] == `SCI_CL_THREE]
					&& !mask_d1[ln]);
		end
	end

	// Read data path: CAS latency 2 or 3, frozen while suspended
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_v          <= 2'h0;
			pipe_d[0]       <= 32'h0000_0000;
			pipe_d[1]       <= 32'h0000_0000;
			link.dq_mem_out <= 32'h0000_0000;
		end else if (cmd_ok && cmd == `SCI_CMD_WR) begin
			pipe_v <= 2'h0;  // A write takes the bus back at once
		end else if (clk_run) begin
			pipe_v[0]       <= beat_do && !beat_wr;
			pipe_d[0]       <= beat_rdata;
			pipe_v[1]       <= pipe_v[0];
			pipe_d[1]       <= pipe_d[0];
			link.dq_mem_out <= pipe_d[mode_reg[`SCI_MR_CL] == `SCI_CL_THREE];
		end
	end

	// --------------------------------------------------------------
	// Refresh
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_row <= 13'h0000;
			self_timer  <= 9'h000;
		end else if (state == sci_pkg::sci_ms_self_refresh) begin
			if (self_timer == 9'(`SCI_REF_CYC - 1)) begin
				self_timer  <= 9'h000;
				refresh_row <= refresh_row + 13'h0001;
			end else begin
				self_timer <= self_timer + 9'h001;
			end
		end else if (cmd_ok && link.cke && cmd == `SCI_CMD_REF && all_idle) begin
			refresh_row <= refresh_row + 13'h0001;
			self_timer  <= 9'h000;
		end
	end
endmodule // sci_mem

// >>> sci_ctrl.sv
// Controller end of the synchronous DRAM command interface: an APB slave
// whose registers order commands, plus refresh and low-power sequencing.
// Assumes the memory shares pclk and the link is joined through sci_if.
`timescale 1ns/1ps
`include "sci_defs.svh"
module sci_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	sci_if.ctrl              link
);
	sci_pkg::sci_ctrl_state_t state;
	sci_pkg::sci_ctrl_state_t ret_state;
	logic [2:0]  ctrl_reg;
	logic [5:0]  cmd_reg;
	logic        cmd_pend;
	logic [12:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [3:0]  mask_reg;
	logic [12:0] mode_shadow;
	logic [11:0] gap_cnt;
	logic [10:0] wr_left;
	logic [2:0]  rd_cnt;
	logic [8:0]  ref_timer;
	logic        ref_due;
	logic        acc;
	logic        mapped;
	logic        issue;
	logic [10:0] words;

	// --------------------------------------------------------------
	// APB slave
	// --------------------------------------------------------------
	assign acc    = psel && penable;
	assign mapped = (paddr == `SCI_REG_CTRL) || (paddr == `SCI_REG_CMD) ||
		(paddr == `SCI_REG_ADDR) || (paddr == `SCI_REG_WDATA) || (paddr == `SCI_REG_RDATA) ||
		(paddr == `SCI_REG_STATUS) || (paddr == `SCI_REG_MASK);
	// A new order waits while the previous one is still queued
	assign pready  = !(pwrite && paddr == `SCI_REG_CMD && cmd_pend);
	assign pslverr = acc && !mapped;
	assign issue   = (state == sci_pkg::sci_cs_idle) && cmd_pend && !(ref_due && ctrl_reg[`SCI_CTRL_REF_EN]);
	assign words   = (mode_shadow[`SCI_MR_BL] == `SCI_BL_1) ? `SCI_WORDS_1 :
		(mode_shadow[`SCI_MR_BL] == `SCI_BL_2) ? `SCI_WORDS_2 :
		(mode_shadow[`SCI_MR_BL] == `SCI_BL_4) ? `SCI_WORDS_4 :
		(mode_shadow[`SCI_MR_BL] == `SCI_BL_8) ? `SCI_WORDS_8 : `SCI_WORDS_PAGE;

	// Read data is latched in the setup cycle so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				`SCI_REG_CTRL:   prdata <= {29'h0, ctrl_reg};
				`SCI_REG_CMD:    prdata <= {26'h0, cmd_reg};
				`SCI_REG_ADDR:   prdata <= {19'h0, addr_reg};
				`SCI_REG_WDATA:  prdata <= wdata_reg;
				`SCI_REG_RDATA:  prdata <= rdata_reg;
				`SCI_REG_STATUS: prdata <= {28'h0, state == sci_pkg::sci_cs_lp, ref_due,
					cmd_pend, state != sci_pkg::sci_cs_idle};
				`SCI_REG_MASK:   prdata <= {28'h0, mask_reg};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= 3'h4;
			cmd_reg   <= 6'h07;
			addr_reg  <= 13'h0000;
			wdata_reg <= 32'h0000_0000;
			mask_reg  <= 4'h0;
		end else if (acc && pwrite && pready) begin
			unique case (paddr)
				`SCI_REG_CTRL:  ctrl_reg  <= pwdata[2:0];
				`SCI_REG_CMD:   cmd_reg   <= pwdata[5:0];
				`SCI_REG_ADDR:  addr_reg  <= pwdata[12:0];
				`SCI_REG_WDATA: wdata_reg <= pwdata;
				`SCI_REG_MASK:  mask_reg  <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_pend <= 1'b0;
		else if (acc && pwrite && pready && paddr == `SCI_REG_CMD)
			cmd_pend <= 1'b1;
		else if (issue)
			cmd_pend <= 1'b0;
	end

	// --------------------------------------------------------------
	// Refresh timer: one row every 64 ms / 8192
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_timer <= 9'h000;
			ref_due   <= 1'b0;
		end else if (state == sci_pkg::sci_cs_lp && ctrl_reg[`SCI_CTRL_SELF]) begin
			ref_timer <= 9'h000;  // The memory refreshes itself here
			ref_due   <= 1'b0;
		end else begin
			if (ref_timer == 9'(`SCI_REF_CYC - 1)) begin
				ref_timer <= 9'h000;
				ref_due   <= 1'b1;
			end else begin
				ref_timer <= ref_timer + 9'h001;
				if (state == sci_pkg::sci_cs_ref)
					ref_due <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Command sequencer
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= sci_pkg::sci_cs_idle;
			ret_state   <= sci_pkg::sci_cs_idle;
			gap_cnt     <= 12'h000;
			mode_shadow <= `SCI_MR_RESET;
			link.cke    <= 1'b1;
			link.cs_n   <= 1'b1;
			{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_NOP;
			link.bank_select <= 2'h0;
			link.addr   <= 13'h0000;
		end else begin
			link.cs_n <= 1'b0;
			{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_NOP;
			unique case (state)
				sci_pkg::sci_cs_idle: begin
					gap_cnt <= 12'(`SCI_RC_CYC);
					state   <= sci_pkg::sci_cs_gap;
					if (ref_due && ctrl_reg[`SCI_CTRL_REF_EN]) begin
						{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_PRE;
						link.addr[`SCI_AP_BIT] <= 1'b1;
						ret_state <= sci_pkg::sci_cs_ref;
					end else if (cmd_pend) begin
						{link.ras_n, link.cas_n, link.we_n} <= cmd_reg[`SCI_CMD_F_CODE];
						link.bank_select <= cmd_reg[`SCI_CMD_F_BANK];
						link.addr <= addr_reg;
						ret_state <= sci_pkg::sci_cs_idle;
						if (cmd_reg[`SCI_CMD_F_CODE] == `SCI_CMD_MRS)
							mode_shadow <= addr_reg;
						if (cmd_reg[`SCI_CMD_F_CODE] == `SCI_CMD_RD ||
							cmd_reg[`SCI_CMD_F_CODE] == `SCI_CMD_WR)
							gap_cnt <= 12'(`SCI_RC_CYC) + {1'b0, words};
					end else if (ctrl_reg[`SCI_CTRL_LP]) begin
						{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_PRE;
						link.addr[`SCI_AP_BIT] <= 1'b1;
						ret_state <= sci_pkg::sci_cs_lp_enter;
					end else begin
						state <= sci_pkg::sci_cs_idle;
					end
				end
				sci_pkg::sci_cs_gap: begin
					gap_cnt <= gap_cnt - 12'h001;
					if (gap_cnt == 12'h001)
						state <= ret_state;
					// A full-page burst wraps forever; stop it right after its last word
					if (gap_cnt == 12'(`SCI_RC_CYC) + 12'h001 && words == `SCI_WORDS_PAGE)
						{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_BST;
				end
				sci_pkg::sci_cs_ref: begin
					{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_REF;
					gap_cnt   <= 12'(`SCI_RC_CYC);
					ret_state <= sci_pkg::sci_cs_idle;
					state     <= sci_pkg::sci_cs_gap;
				end
				sci_pkg::sci_cs_lp_enter: begin
					link.cke <= 1'b0;
					if (ctrl_reg[`SCI_CTRL_SELF])
						{link.ras_n, link.cas_n, link.we_n} <= `SCI_CMD_REF;
					else
						link.cs_n <= 1'b1;
					state <= sci_pkg::sci_cs_lp;
				end
				sci_pkg::sci_cs_lp: begin
					link.cs_n <= 1'b1;
					if (!ctrl_reg[`SCI_CTRL_LP] || ref_due) begin
						link.cke  <= 1'b1;
						gap_cnt   <= 12'(`SCI_RC_CYC);
						ret_state <= sci_pkg::sci_cs_idle;
						state     <= sci_pkg::sci_cs_gap;
					end
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Data lanes: write drive and read capture
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_left           <= 11'h000;
			link.dq_ctrl_oe_n <= 1'b1;
			link.dq_ctrl_out  <= 32'h0000_0000;
			{link.lane_d_mask, link.lane_c_mask, link.lane_b_mask, link.lane_a_mask} <= 4'h0;
		end else begin
			{link.lane_d_mask, link.lane_c_mask, link.lane_b_mask, link.lane_a_mask} <= mask_reg;
			link.dq_ctrl_out <= wdata_reg;
			if (issue && cmd_reg[`SCI_CMD_F_CODE] == `SCI_CMD_WR) begin
				link.dq_ctrl_oe_n <= 1'b0;
				wr_left <= mode_shadow[`SCI_MR_WB] ? 11'h000 : words - 11'h001;
			end else if (wr_left != 11'h000) begin
				wr_left <= wr_left - 11'h001;
			end else begin
				link.dq_ctrl_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cnt    <= 3'h0;
			rdata_reg <= 32'h0000_0000;
		end else if (issue && cmd_reg[`SCI_CMD_F_CODE] == `SCI_CMD_RD) begin
			rd_cnt <= mode_shadow[`SCI_MR_CL] + 3'h1;
		end else if (rd_cnt != 3'h0) begin
			rd_cnt <= rd_cnt - 3'h1;
			if (rd_cnt == 3'h1)
				rdata_reg <= link.dq;
		end
	end
endmodule // sci_ctrl

// >>> sci_link_sva.sv
// Assertions on the pin link between the controller and the memory.
// Takes sci_if signals as plain inputs; placed beside the interface.
`timescale 1ns/1ps
`include "sci_defs.svh"
module sci_link_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input wire logic       lane_a_mask,
	input wire logic       lane_b_mask,
	input wire logic       lane_c_mask,
	input wire logic       lane_d_mask,
	input wire logic [3:0] dq_mem_oe_n,
	input wire logic       dq_ctrl_oe_n
);
	// ----------
	// Link rules
	// ----------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] code;
	assign code = {ras_n, cas_n, we_n};
	sequence cmd_s; !cs_n && code != `SCI_CMD_NOP; endsequence
	sequence idle_s; cs_n || code == `SCI_CMD_NOP; endsequence
	a_cmd_spacing: assert property (cmd_s |=> idle_s [*3])
		else $error("commands too close");
	a_no_fight: assert property (dq_ctrl_oe_n || dq_mem_oe_n == 4'hf)
		else $error("both ends drive data");
	a_write_drive: assert property ($fell(dq_ctrl_oe_n) |-> !cs_n && code == `SCI_CMD_WR)
		else $error("data driven without write");
	a_lp_quiet: assert property (!cke && $past(!cke) |-> idle_s)
		else $error("command while clock gated");
	// Clock must run two edges, or the read pipe is frozen
	a_lane_a_float: assert property (lane_a_mask && cke ##1 cke |=> dq_mem_oe_n[0])
		else $error("masked lane a driven");
	a_lane_b_float: assert property (lane_b_mask && cke ##1 cke |=> dq_mem_oe_n[1])
		else $error("masked lane b driven");
	a_lane_c_float: assert property (lane_c_mask && cke ##1 cke |=> dq_mem_oe_n[2])
		else $error("masked lane c driven");
	a_lane_d_float: assert property (lane_d_mask && cke ##1 cke |=> dq_mem_oe_n[3])
		else $error("masked lane d driven");
endmodule // sci_link_sva

// >>> test_sdram_command_interface.sv
// Bench: APB orders drive the controller, which talks to the memory.
// Assumes both ends share pclk and one sci_if joins them.
`timescale 1ns/1ps
`include "sci_defs.svh"
module test_sdram_command_interface;
	// -----
	// Bench
	// -----
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, err;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, d1, d2, e;
	logic [3:0]  bank_open, ob;
	logic [1:0]  mem_state;
	logic [12:0] refresh_row, col;
	int          n_mismatch = 0, samples_checked = 0, bl[5] = '{0, 1, 2, 3, 7};
	sci_if sci_if_inst ();
	sci_mem sci_mem_inst (.pclk(pclk), .presetn(presetn), .link(sci_if_inst.mem),
		.bank_open(bank_open), .mem_state(mem_state), .refresh_row(refresh_row));
	sci_ctrl sci_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(sci_if_inst.ctrl));
	sci_link_sva sci_link_sva_inst (.pclk(pclk), .presetn(presetn), .cke(sci_if_inst.cke),
		.cs_n(sci_if_inst.cs_n), .ras_n(sci_if_inst.ras_n), .cas_n(sci_if_inst.cas_n),
		.we_n(sci_if_inst.we_n), .lane_a_mask(sci_if_inst.lane_a_mask),
		.lane_b_mask(sci_if_inst.lane_b_mask), .lane_c_mask(sci_if_inst.lane_c_mask),
		.lane_d_mask(sci_if_inst.lane_d_mask), .dq_mem_oe_n(sci_if_inst.dq_mem_oe_n),
		.dq_ctrl_oe_n(sci_if_inst.dq_ctrl_oe_n));
	always #12.5 pclk = ~pclk;
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Status poll keeps us off the link until the controller is free
	task cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		apb(1, `SCI_REG_ADDR, {19'h0, a});
		apb(1, `SCI_REG_CMD, {26'h0, b, 1'b0, c});
		do apb(0, `SCI_REG_STATUS, 0); while (q[1:0] !== 2'b00);
	endtask
	task wait_state(input logic [1:0] v);
		for (int n = 0; n < 400 && mem_state !== v; n++) @(posedge pclk);
		chk("mem_state", v, mem_state);
	endtask
	task finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h4be3c287));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `SCI_REG_CTRL, 0);
		chk("ctrl reset", 32'h4, q);
		// Refresh off here: its precharge-all would close banks under the bank_open checks
		apb(1, `SCI_REG_CTRL, 0);
		apb(1, 8'h1c, 32'hffffffff);
		chk("unmapped err", 1, err);
		apb(0, 8'h1c, 0);
		chk("unmapped data", 0, q);
		ob = 4'h0;
		for (int b = 0; b < 4; b++) begin
			d1 = $urandom();
			d2 = $urandom();
			col = {3'h0, 10'($urandom())};
			apb(1, `SCI_REG_MASK, 0);
			apb(1, `SCI_REG_WDATA, d1);
			cmd(`SCI_CMD_ACT, 2'(b), 13'($urandom()));
			cmd(`SCI_CMD_WR, 2'(b), col);
			apb(1, `SCI_REG_WDATA, d2);
			apb(1, `SCI_REG_MASK, 1 << b);
			cmd(`SCI_CMD_WR, 2'(b), col);
			e = d2;
			e[8*b +: 8] = d1[8*b +: 8];
			apb(1, `SCI_REG_MASK, 0);
			cmd(`SCI_CMD_RD, 2'(b), col);
			apb(0, `SCI_REG_RDATA, 0);
			chk("masked write", e, q);
			e[8*((b+1)%4) +: 8] = 8'h00;
			apb(1, `SCI_REG_MASK, 1 << ((b + 1) % 4));
			cmd(`SCI_CMD_RD, 2'(b), col | {b[0], 10'h0});
			apb(0, `SCI_REG_RDATA, 0);
			chk("masked read", e, q);
			ob[b] = !b[0];
			chk("bank_open", ob, bank_open);
		end
		apb(1, `SCI_REG_MASK, 0);
		cmd(`SCI_CMD_PRE, 2, 0);
		chk("single close", 4'h1, bank_open);
		cmd(`SCI_CMD_PRE, 2, 13'h0400);
		chk("all close", 4'h0, bank_open);
		apb(1, `SCI_REG_CTRL, 4);
		foreach (bl[i]) begin
			cmd(`SCI_CMD_MRS, 0, 13'(13'h0020 | bl[i] | (i % 2) << 3 | (i % 2) << 4 |
				(i % 3 == 0) << 9));
			d1 = $urandom();
			apb(1, `SCI_REG_WDATA, d1);
			cmd(`SCI_CMD_ACT, 1, 0);
			cmd(`SCI_CMD_WR, 1, 4);
			cmd(`SCI_CMD_RD, 1, 4);
			apb(0, `SCI_REG_RDATA, 0);
			chk("burst read", d1, q);
			cmd(`SCI_CMD_PRE, 0, 13'h0400);
		end
		for (int k = 0; k < 2; k++) begin
			apb(1, `SCI_REG_CTRL, k ? 7 : 5);
			wait_state(k ? 2 : 1);
			apb(1, `SCI_REG_CTRL, 4);
			wait_state(0);
		end
		chk("refresh row moved", 1, refresh_row != 13'h0);
		finish_test();
	end
endmodule // test_sdram_command_interface
